// *** srap_pkg.sv ***
// Function
// - config bit 3 of register 0x0b selects three-wire mode; clear selects four-wire.
// - four-wire link uses serial clock, chip select low, data in, separate data out.
// - three-wire mode merges data in and out on one shared bidirectional pin.
// - serial clock activity while chip select is high is ignored.
// - command 000xxxxx followed by one byte loads the address pointer.
// - 010xxxxx writes next byte at pointer; 100xxxxx returns byte at pointer.
// - 011xxxxx and 101xxxxx act likewise, then advance the pointer by one.
// - exact command 0xe0, start address, then data bytes to successive addresses.
// - burst write runs for any number of bytes until chip select rises.
// - burst address wraps from 255 to zero for the following byte.
`default_nettype none
package srap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 256;
  // synchroniser vector layout
  localparam int IN_W     = 4;
  localparam int IN_SCLK  = 3;
  localparam int IN_CS    = 2;
  localparam int IN_SDI   = 1;
  localparam int IN_SDIO  = 0;
  localparam logic [IN_W-1:0] IN_RST = 4'h4;
  // command byte fields
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 5;
  localparam logic [2:0] OP_SET_ADDR = 3'h0;
  localparam logic [2:0] OP_WRITE    = 3'h2;
  localparam logic [2:0] OP_WRITE_INC = 3'h3;
  localparam logic [2:0] OP_READ     = 3'h4;
  localparam logic [2:0] OP_READ_INC = 3'h5;
  localparam logic [DATA_W-1:0] CMD_BURST = 8'he0;
  // mode configuration location
  localparam logic [ADDR_W-1:0] MODE_REG = 8'h0b;
  localparam int MODE_BIT = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] PTR_STEP = 8'h01;
  localparam logic [ADDR_W-1:0] PTR_TOP  = 8'hff;
  localparam logic [ADDR_W-1:0] PTR_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] MEM_RST  = 8'h00;

  typedef enum logic [2:0] {
    ST_CMD    = 3'h0,
    ST_ADDR   = 3'h1,
    ST_WDATA  = 3'h2,
    ST_RDATA  = 3'h3,
    ST_BADDR  = 3'h4,
    ST_BDATA  = 3'h5,
    ST_IGNORE = 3'h6
  } srap_state_type;
endpackage
`default_nettype wire

// *** srap_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module srap_port (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // serial link from host
  input  wire logic sclk,
  input  wire logic chip_select_n,
  input  wire logic sdi,
  // four-wire data out
  output var  logic sdo,
  // three-wire shared data pin
  input  wire logic sdio_in,
  output var  logic sdio_out,
  output var  logic sdio_oe_n,
  // mode status
  output var  logic three_wire_select
);

  logic [srap_pkg::IN_W-1:0]   sync1;
  logic [srap_pkg::IN_W-1:0]   sync2;
  logic [srap_pkg::IN_W-1:0]   sync3;
  logic [srap_pkg::IN_W-1:0]   filt;
  logic [srap_pkg::IN_W-1:0]   filt_d;
  logic [srap_pkg::IN_W-1:0]   next_filt;
  logic [srap_pkg::DATA_W-1:0] mem [srap_pkg::DEPTH];
  logic [srap_pkg::ADDR_W-1:0] ptr;
  logic [srap_pkg::ADDR_W-1:0] next_ptr;
  logic [2:0]                  bit_cnt;
  logic [srap_pkg::DATA_W-1:0] shift_in;
  logic [srap_pkg::DATA_W-1:0] out_shift;
  logic                        incr;
  logic                        out_bit;
  srap_pkg::srap_state_type    state;
  srap_pkg::srap_state_type    next_state;

  wire                         selected   = ~filt[srap_pkg::IN_CS];
  wire                         cs_rise    = filt[srap_pkg::IN_CS] & ~filt_d[srap_pkg::IN_CS];
  wire                         sclk_rise  = filt[srap_pkg::IN_SCLK] & ~filt_d[srap_pkg::IN_SCLK];
  wire                         sclk_fall  = ~filt[srap_pkg::IN_SCLK] & filt_d[srap_pkg::IN_SCLK];
  wire                         mode3      = mem[srap_pkg::MODE_REG][srap_pkg::MODE_BIT];
  wire                         din        = mode3 ? filt[srap_pkg::IN_SDIO] : filt[srap_pkg::IN_SDI];
  wire                         bit_take   = sclk_rise & selected;
  wire                         byte_done  = bit_take & (bit_cnt == srap_pkg::BIT_LAST);
  wire [srap_pkg::DATA_W-1:0]  byte_val   = {shift_in[srap_pkg::DATA_W-2:0], din};
  wire [2:0]                   opcode     = byte_val[srap_pkg::OP_MSB:srap_pkg::OP_LSB];
  wire                         is_write   = (state == srap_pkg::ST_WDATA) | (state == srap_pkg::ST_BDATA);
  wire                         wr_en      = byte_done & is_write;
  wire                         is_read_op = (opcode == srap_pkg::OP_READ) | (opcode == srap_pkg::OP_READ_INC);
  wire                         load_out   = byte_done & (state == srap_pkg::ST_CMD) & is_read_op;
  wire                         shift_out  = sclk_fall & selected & (state == srap_pkg::ST_RDATA);
  wire                         drive3     = mode3 & selected & (state == srap_pkg::ST_RDATA);
  wire [srap_pkg::ADDR_W-1:0]  ptr_inc    = ptr + srap_pkg::PTR_STEP;

  // three-stage input sampling, change taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < srap_pkg::IN_W; gi++) begin : g_sync
      assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1  <= srap_pkg::IN_RST;
      sync2  <= srap_pkg::IN_RST;
      sync3  <= srap_pkg::IN_RST;
      filt   <= srap_pkg::IN_RST;
      filt_d <= srap_pkg::IN_RST;
    end else begin
      sync1  <= {sclk, chip_select_n, sdi, sdio_in};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  // command decode and byte sequencing
  always_comb begin
    next_state = state;
    next_ptr   = ptr;
    if (byte_done) begin
      unique case (state)
        srap_pkg::ST_CMD: begin
          if (byte_val == srap_pkg::CMD_BURST) begin
            next_state = srap_pkg::ST_BADDR;
          end else if (opcode == srap_pkg::OP_SET_ADDR) begin
            next_state = srap_pkg::ST_ADDR;
          end else if (opcode == srap_pkg::OP_WRITE || opcode == srap_pkg::OP_WRITE_INC) begin
            next_state = srap_pkg::ST_WDATA;
          end else if (is_read_op) begin
            next_state = srap_pkg::ST_RDATA;
          end else begin
            next_state = srap_pkg::ST_IGNORE;
          end
        end
        srap_pkg::ST_ADDR: begin
          next_ptr   = byte_val;
          next_state = srap_pkg::ST_CMD;
        end
        srap_pkg::ST_WDATA, srap_pkg::ST_RDATA: begin
          next_ptr   = incr ? ptr_inc : ptr;
          next_state = srap_pkg::ST_CMD;
        end
        srap_pkg::ST_BADDR: begin
          next_ptr   = byte_val;
          next_state = srap_pkg::ST_BDATA;
        end
        srap_pkg::ST_BDATA: begin
          next_ptr   = ptr_inc;
          next_state = srap_pkg::ST_BDATA;
        end
        srap_pkg::ST_IGNORE: begin
          next_state = srap_pkg::ST_IGNORE;
        end
        default: begin
          next_state = srap_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // deselect ends any command; pointer survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= srap_pkg::ST_CMD;
      ptr   <= srap_pkg::PTR_ZERO;
      incr  <= 1'b0;
    end else begin
      state <= selected ? next_state : srap_pkg::ST_CMD;
      ptr   <= next_ptr;
      if (byte_done && state == srap_pkg::ST_CMD) begin
        incr <= opcode[0];
      end
    end
  end

  // msb-first shift in on rising clock edge while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= 3'h0;
      shift_in <= srap_pkg::MEM_RST;
    end else if (!selected) begin
      bit_cnt  <= 3'h0;
    end else if (bit_take) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= byte_val;
    end
  end

  // register space
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < srap_pkg::DEPTH; i++) begin
        mem[i] <= srap_pkg::MEM_RST;
      end
    end else if (wr_en) begin
      mem[ptr] <= byte_val;
    end
  end

  // read data shifted out msb first on falling clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift <= srap_pkg::MEM_RST;
      out_bit   <= 1'b0;
    end else if (load_out) begin
      out_shift <= mem[ptr];
    end else if (shift_out) begin
      out_bit   <= out_shift[srap_pkg::DATA_W-1];
      out_shift <= {out_shift[srap_pkg::DATA_W-2:0], 1'b0};
    end
  end

  // pin drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo               <= 1'b0;
      sdio_out          <= 1'b0;
      sdio_oe_n         <= 1'b1;
      three_wire_select <= 1'b0;
    end else begin
      sdo               <= out_bit;
      sdio_out          <= out_bit;
      sdio_oe_n         <= ~drive3;
      three_wire_select <= mode3;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_four_wire_no_drive;
    !mode3 |=> sdio_oe_n;
  endproperty
  a_four_wire_no_drive: assert property (p_four_wire_no_drive) else $error("pin driven in four-wire mode");

  property p_three_wire_drive;
    !sdio_oe_n |-> $past(mode3) && $past(state) == srap_pkg::ST_RDATA;
  endproperty
  a_three_wire_drive: assert property (p_three_wire_drive) else $error("shared pin driven outside read");

  property p_out_bit;
    shift_out |=> ##1 sdo == $past(out_shift[srap_pkg::DATA_W-1], 2);
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("data out bit wrong");

  property p_idle_clock;
    !selected |=> bit_cnt == 3'h0 && $stable(ptr);
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock acted while deselected");

  property p_set_addr;
    byte_done && state == srap_pkg::ST_ADDR |=> ptr == $past(byte_val);
  endproperty
  a_set_addr: assert property (p_set_addr) else $error("pointer not loaded");

  property p_write;
    wr_en |=> mem[$past(ptr)] == $past(byte_val);
  endproperty
  a_write: assert property (p_write) else $error("write data not stored");

  property p_incr;
    byte_done && incr && (state == srap_pkg::ST_WDATA || state == srap_pkg::ST_RDATA)
      |=> ptr == $past(ptr_inc);
  endproperty
  a_incr: assert property (p_incr) else $error("pointer not advanced");

  property p_burst_cmd;
    byte_done && state == srap_pkg::ST_CMD && byte_val == srap_pkg::CMD_BURST && !cs_rise
      |=> state == srap_pkg::ST_BADDR;
  endproperty
  a_burst_cmd: assert property (p_burst_cmd) else $error("burst command missed");

  property p_burst_hold;
    state == srap_pkg::ST_BDATA && selected |=> state == srap_pkg::ST_BDATA;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst ended while selected");

  property p_wrap;
    wr_en && state == srap_pkg::ST_BDATA && ptr == srap_pkg::PTR_TOP |=> ptr == srap_pkg::PTR_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst address did not wrap");

  property p_keep_ptr;
    cs_rise |=> $stable(ptr);
  endproperty
  a_keep_ptr: assert property (p_keep_ptr) else $error("pointer lost at deselect");

  property p_deselect_ends;
    !selected |=> state == srap_pkg::ST_CMD;
  endproperty
  a_deselect_ends: assert property (p_deselect_ends) else $error("command outlived deselect");

  property p_cmd_set_addr;
    byte_done && state == srap_pkg::ST_CMD && opcode == srap_pkg::OP_SET_ADDR
      |=> state == srap_pkg::ST_ADDR;
  endproperty
  a_cmd_set_addr: assert property (p_cmd_set_addr) else $error("set address command missed");

  property p_cmd_write;
    byte_done && state == srap_pkg::ST_CMD && (opcode == srap_pkg::OP_WRITE || opcode == srap_pkg::OP_WRITE_INC)
      |=> state == srap_pkg::ST_WDATA;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("write command missed");

  property p_cmd_read;
    byte_done && state == srap_pkg::ST_CMD && is_read_op |=> state == srap_pkg::ST_RDATA;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("read command missed");

  property p_read_load;
    load_out |=> out_shift == mem[$past(ptr)];
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not loaded");

  property p_plain_keep;
    byte_done && !incr && (state == srap_pkg::ST_WDATA || state == srap_pkg::ST_RDATA)
      |=> ptr == $past(ptr);
  endproperty
  a_plain_keep: assert property (p_plain_keep) else $error("pointer moved on plain access");

  property p_burst_addr;
    byte_done && state == srap_pkg::ST_BADDR |=> ptr == $past(byte_val) && state == srap_pkg::ST_BDATA;
  endproperty
  a_burst_addr: assert property (p_burst_addr) else $error("burst start address not taken");

  property p_burst_step;
    wr_en && state == srap_pkg::ST_BDATA |=> ptr == $past(ptr_inc);
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst address not advanced");

  property p_bit_count;
    bit_take |=> bit_cnt == $past(bit_cnt) + 3'h1;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit count not advanced");

  property p_mode_status;
    three_wire_select == $past(mode3);
  endproperty
  a_mode_status: assert property (p_mode_status) else $error("mode status wrong");

  property p_out_hold;
    !shift_out |=> ##1 $stable(sdo);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("data out changed without a falling clock");

endmodule
`default_nettype wire

// *** srap_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module srap_host (
  // link to device
  output var  logic sclk,
  output var  logic chip_select_n,
  output var  logic sdi,
  output var  logic sdio_in,
  // device answers
  input  wire logic sdo,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n
);
  logic bit_out;
  logic host_en;
  logic mode3;
  // a released line shows the inverse of its last bit
  always_comb sdi = (host_en && !mode3) ? bit_out : ~bit_out;
  always_comb sdio_in = !sdio_oe_n ? sdio_out : ((host_en && mode3) ? bit_out : ~bit_out);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    bit_out = 1'b0;
    host_en = 1'b0;
    mode3 = 1'b0;
  end
  task automatic frame_start;
    #40 chip_select_n = 1'b0;
    #100;
  endtask
  task automatic frame_end;
    #100 chip_select_n = 1'b1;
    host_en = 1'b0;
    #300;
  endtask
  // read bit taken mid high phase: after it settles, before the shared pin is let go
  task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      host_en = drive;
      bit_out = tx[i];
      #62.5 sclk = 1'b1;
      #25 rx[i] = mode3 ? sdio_in : sdo;
      #37.5 sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk;
  logic rst_n;
  logic sclk, chip_select_n, sdi, sdo, sdio_in, sdio_out, sdio_oe_n, three_wire_select;
  int failures;
  int checks;
  int seed;
  int cycles;
  logic [7:0] ref_mem [256];
  logic [7:0] rx;
  logic [7:0] a;
  srap_port i_srap_port (.clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
    .sdo(sdo), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .three_wire_select(three_wire_select));
  srap_host i_srap_host (.sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi), .sdio_in(sdio_in),
    .sdo(sdo), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end
  function automatic logic [7:0] safe(input logic [7:0] p);
    return (p == srap_pkg::MODE_REG) ? 8'h0c : p;
  endfunction
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0s expected %h seen %h", name, exp, got);
    end
  endtask
  // command byte with random don't-care bits, then one byte
  task automatic put(input logic [2:0] opc, input logic [7:0] d);
    i_srap_host.xfer({opc, 5'($random(seed))}, 1'b1, rx);
    i_srap_host.xfer(d, !(opc == srap_pkg::OP_READ || opc == srap_pkg::OP_READ_INC), rx);
  endtask
  task automatic op(input logic [2:0] opc, input logic [7:0] d);
    i_srap_host.frame_start();
    put(opc, d);
    i_srap_host.frame_end();
  endtask
  initial begin
    seed = 79891;
    failures = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    foreach (ref_mem[k]) ref_mem[k] = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("sdio_oe_n", 8'h01, {7'h00, sdio_oe_n});
    chk("three_wire", 8'h00, {7'h00, three_wire_select});
    chk("sdo", 8'h00, {7'h00, sdo});
    for (int n = 0; n < 4; n++) begin
      a = safe(8'($random(seed)));
      op(srap_pkg::OP_SET_ADDR, a);
      op(srap_pkg::OP_READ, 8'h00);
      chk("reset_read", ref_mem[a], rx);
      ref_mem[a] = 8'($random(seed));
      op(srap_pkg::OP_WRITE, ref_mem[a]);
      i_srap_host.xfer(8'($random(seed)), 1'b1, rx);
      op(srap_pkg::OP_SET_ADDR, a);
      op(srap_pkg::OP_READ, 8'h00);
      chk("read", ref_mem[a], rx);
    end
    $display("test single done");
    a = {2'h1, 6'($random(seed))};
    i_srap_host.frame_start();
    put(srap_pkg::OP_SET_ADDR, a);
    for (int k = 0; k < 3; k++) begin
      ref_mem[8'(a + k)] = 8'($random(seed));
      put(srap_pkg::OP_WRITE_INC, ref_mem[8'(a + k)]);
    end
    i_srap_host.frame_end();
    i_srap_host.frame_start();
    put(srap_pkg::OP_SET_ADDR, a);
    for (int k = 0; k < 3; k++) begin
      put(srap_pkg::OP_READ_INC, 8'h00);
      chk("read_inc", ref_mem[8'(a + k)], rx);
    end
    i_srap_host.frame_end();
    op(srap_pkg::OP_READ, 8'h00);
    chk("ptr_kept", ref_mem[8'(a + 3)], rx);
    $display("test increment done");
    i_srap_host.frame_start();
    i_srap_host.xfer(srap_pkg::CMD_BURST, 1'b1, rx);
    i_srap_host.xfer(8'hfd, 1'b1, rx);
    for (int k = 0; k < 4; k++) begin
      ref_mem[8'(8'hfd + k)] = 8'($random(seed));
      i_srap_host.xfer(ref_mem[8'(8'hfd + k)], 1'b1, rx);
    end
    i_srap_host.frame_end();
    i_srap_host.frame_start();
    i_srap_host.xfer(8'hc0, 1'b1, rx);
    i_srap_host.xfer(8'h55, 1'b1, rx);
    i_srap_host.frame_end();
    i_srap_host.frame_start();
    put(srap_pkg::OP_SET_ADDR, 8'hfd);
    for (int k = 0; k < 4; k++) begin
      put(srap_pkg::OP_READ_INC, 8'h00);
      chk("burst", ref_mem[8'(8'hfd + k)], rx);
    end
    put(srap_pkg::OP_READ, 8'h00);
    chk("ignored", ref_mem[8'h01], rx);
    i_srap_host.frame_end();
    $display("test burst done");
    op(srap_pkg::OP_SET_ADDR, srap_pkg::MODE_REG);
    op(srap_pkg::OP_WRITE, 8'h08);
    chk("three_wire", 8'h01, {7'h00, three_wire_select});
    i_srap_host.mode3 = 1'b1;
    op(srap_pkg::OP_READ, 8'h00);
    chk("read_3w", 8'h08, rx);
    op(srap_pkg::OP_SET_ADDR, a);
    op(srap_pkg::OP_READ, 8'h00);
    chk("read_3w", ref_mem[a], rx);
    op(srap_pkg::OP_SET_ADDR, srap_pkg::MODE_REG);
    op(srap_pkg::OP_WRITE, 8'h00);
    i_srap_host.mode3 = 1'b0;
    chk("three_wire", 8'h00, {7'h00, three_wire_select});
    $display("test mode done");
    conclude();
  end
endmodule
`default_nettype wire
